// [shared/serial_flow_regs.svh]
// constants for the serial flow-control block
// assumes 8-bit characters handed over by an external shifter
`ifndef SERIAL_FLOW_REGS_SVH
`define SERIAL_FLOW_REGS_SVH

`define SFC_PAUSE_CHR 8'h13
`define SFC_RESUME_CHR 8'h11
`define SFC_DATA_W 8
`define SFC_FIFO_DEPTH 8

`endif

// [shared/serial_flow_pkg.sv]
// types shared by the serial flow-control block
// assumes nothing beyond the constants header
package serial_flow_pkg;

	typedef enum logic [1:0] {
		PORT_RS232 = 2'b00,
		PORT_RS422 = 2'b01,
		PORT_RS485 = 2'b10
	} port_mode_type;

	typedef enum logic [2:0] {
		FLOW_NONE = 3'b000,
		FLOW_INBAND = 3'b001,
		FLOW_MODEM = 3'b010,
		FLOW_CROSS = 3'b011,
		FLOW_DTR = 3'b100
	} flow_mode_type;

	typedef enum logic [1:0] {
		OUT_IDLE = 2'b00,
		OUT_DATA = 2'b01,
		OUT_CTRL = 2'b10
	} out_state_type;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} chr_type;

endpackage : serial_flow_pkg

// [hdl/serial_flow_control.sv]
// flow control for one serial port: in-band pause/resume and rts/cts/dtr handshaking
// assumes an external shifter/deserializer on I_MCLK exchanging whole characters
//
// Contract
// - pause character is byte 19; receiving it suspends our transmitter.
// - resume character is byte 17; receiving it lets a paused transmitter resume.
// - when we must postpone input, send pause; when ready again, send resume.
// - a pause stops only traffic toward its issuer; the other direction continues.
// - classic handshake: rts asserted while we have data waiting to send.
// - data characters start only while clear-to-send is asserted.
// - null-modem: our rts means we can receive; peer rts feeds our cts.
// - port mode rs232, rs422 or rs485; cleared configuration gives rs232.
// - with rts looped back, dtr flags acceptance and dsr gates sending.
`timescale 1ns/1ps
`default_nettype none
`include "serial_flow_regs.svh"

module sfc_fifo #(
	parameter int WIDTH = `SFC_DATA_W,
	parameter int DEPTH = `SFC_FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_valid,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_ready,
	output logic o_valid,
	output logic [WIDTH-1:0] o_data,
	input wire logic i_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign o_ready = i_ce && (cnt_q != (AW + 1)'(DEPTH));
	assign o_valid = i_ce && (cnt_q != '0);
	assign o_data = mem_q[rd_q];
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;

	always_comb begin
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wr_q] = i_data;
			wr_d = bump(wr_q);
		end
		if (pop) begin
			rd_d = bump(rd_q);
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (i_ce) begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
		if (i_ce) begin
			mem_q <= mem_d;
		end
	end
endmodule : sfc_fifo

module serial_flow_control (
	input wire logic I_MCLK,
	input wire logic I_RST,
	input wire logic I_CE,
	input wire logic I_CFG_CLEAR,
	input wire logic I_MODE_LOAD,
	input wire serial_flow_pkg::port_mode_type I_MODE,
	input wire serial_flow_pkg::flow_mode_type I_FLOW,
	output serial_flow_pkg::port_mode_type O_MODE,
	input wire logic I_TX_VALID,
	input wire logic [7:0] I_TX_DATA,
	output logic O_TX_READY,
	output logic O_CHR_VALID,
	output logic [7:0] O_CHR_DATA,
	input wire logic I_CHR_READY,
	input wire serial_flow_pkg::chr_type I_RXC,
	output serial_flow_pkg::chr_type O_RX,
	input wire logic I_RX_HOLD,
	input wire logic I_CTS,
	input wire logic I_DSR,
	output logic O_RTS,
	output logic O_DTR,
	output logic O_TX_PAUSED
);
	serial_flow_pkg::port_mode_type mode_q, mode_d;
	serial_flow_pkg::out_state_type state_q, state_d;
	serial_flow_pkg::chr_type rx_q, rx_d;
	logic [7:0] chr_q, chr_d;
	// bit 0 cts, bit 1 dsr
	logic [1:0] s1_q, s2_q, s3_q, pin_q, pin_d;
	logic paused_q, paused_d, told_q, told_d, rts_q, rts_d, dtr_q, dtr_d;
	logic inband, is_pause, is_resume, flow_chr, link_ok, free, ctl_due;
	logic fifo_valid, fifo_pop;
	logic [7:0] fifo_data;

	sfc_fifo #(.WIDTH(`SFC_DATA_W), .DEPTH(`SFC_FIFO_DEPTH)) tx_fifo (
		.i_clk(I_MCLK),
		.i_rst(I_RST),
		.i_ce(I_CE),
		.i_valid(I_TX_VALID),
		.i_data(I_TX_DATA),
		.o_ready(O_TX_READY),
		.o_valid(fifo_valid),
		.o_data(fifo_data),
		.i_ready(fifo_pop)
	);

	assign inband = (I_FLOW == serial_flow_pkg::FLOW_INBAND);
	assign is_pause = I_RXC.valid && (I_RXC.data == `SFC_PAUSE_CHR);
	assign is_resume = I_RXC.valid && (I_RXC.data == `SFC_RESUME_CHR);
	// payload bytes equal to the codes would be eaten here, so the far end must avoid them
	assign flow_chr = inband && (is_pause || is_resume);

	// a received pause only gates our sending; reception below is untouched
	always_comb begin
		case (I_FLOW)
			serial_flow_pkg::FLOW_NONE: link_ok = 1'b1;
			serial_flow_pkg::FLOW_INBAND: link_ok = !paused_q;
			serial_flow_pkg::FLOW_MODEM: link_ok = pin_q[0];
			serial_flow_pkg::FLOW_CROSS: link_ok = pin_q[0];
			serial_flow_pkg::FLOW_DTR: link_ok = pin_q[1];
			default: link_ok = 1'b0;
		endcase
	end

	// control characters bypass the pause so a paused link with no data character withheld in chr_q can still be told to stop
	assign O_CHR_VALID = I_CE && ((state_q == serial_flow_pkg::OUT_CTRL)
		|| (state_q == serial_flow_pkg::OUT_DATA && link_ok));
	assign O_CHR_DATA = chr_q;
	assign free = (state_q == serial_flow_pkg::OUT_IDLE) || (O_CHR_VALID && I_CHR_READY);
	assign ctl_due = inband && (I_RX_HOLD != told_q);
	// the character already taken by the shifter finishes; nothing new leaves while held
	assign fifo_pop = I_CE && free && !ctl_due && link_ok && fifo_valid;
	assign O_MODE = mode_q;
	assign O_RX = rx_q;
	assign O_RTS = rts_q;
	assign O_DTR = dtr_q;
	assign O_TX_PAUSED = paused_q;

	always_comb begin
		mode_d = mode_q;
		if (I_CFG_CLEAR) begin
			mode_d = serial_flow_pkg::PORT_RS232;
		end else if (I_MODE_LOAD && I_MODE != 2'h3) begin
			mode_d = I_MODE;
		end
		// a pin change counts once the second and third stages agree
		pin_d = (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
		paused_d = paused_q;
		if (!inband) begin
			paused_d = 1'b0;
		end else if (is_pause) begin
			paused_d = 1'b1;
		end else if (is_resume) begin
			paused_d = 1'b0;
		end
		rx_d.valid = I_RXC.valid && !flow_chr;
		rx_d.data = I_RXC.valid ? I_RXC.data : rx_q.data;
		state_d = state_q;
		chr_d = chr_q;
		told_d = inband ? told_q : 1'b0;
		if (free) begin
			if (ctl_due) begin
				state_d = serial_flow_pkg::OUT_CTRL;
				chr_d = I_RX_HOLD ? `SFC_PAUSE_CHR : `SFC_RESUME_CHR;
				told_d = I_RX_HOLD;
			end else if (fifo_pop) begin
				state_d = serial_flow_pkg::OUT_DATA;
				chr_d = fifo_data;
			end else begin
				state_d = serial_flow_pkg::OUT_IDLE;
			end
		end
		case (I_FLOW)
			serial_flow_pkg::FLOW_MODEM: rts_d = fifo_valid
				|| (state_q == serial_flow_pkg::OUT_DATA);
			serial_flow_pkg::FLOW_CROSS: rts_d = !I_RX_HOLD;
			default: rts_d = 1'b1; // looped back in dtr mode, so it must not gate
		endcase
		dtr_d = (I_FLOW == serial_flow_pkg::FLOW_DTR) ? !I_RX_HOLD : 1'b1;
	end

	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			mode_q <= serial_flow_pkg::PORT_RS232;
			state_q <= serial_flow_pkg::OUT_IDLE;
			chr_q <= 8'h00;
			rx_q <= '0;
			s1_q <= 2'h0;
			s2_q <= 2'h0;
			s3_q <= 2'h0;
			pin_q <= 2'h0;
			paused_q <= 1'b0;
			told_q <= 1'b0;
			rts_q <= 1'b0;
			dtr_q <= 1'b0;
		end else if (I_CE) begin
			mode_q <= mode_d;
			state_q <= state_d;
			chr_q <= chr_d;
			rx_q <= rx_d;
			s1_q <= {I_DSR, I_CTS};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= pin_d;
			paused_q <= paused_d;
			told_q <= told_d;
			rts_q <= rts_d;
			dtr_q <= dtr_d;
		end
	end

	a_pause_code: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_CE && inband && I_RXC.valid && I_RXC.data == `SFC_PAUSE_CHR |=> O_TX_PAUSED)
		else $error("pause character did not pause the transmitter");

	a_resume_code: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_CE && inband && I_RXC.valid && I_RXC.data == `SFC_RESUME_CHR |=> !O_TX_PAUSED)
		else $error("resume character did not release the transmitter");

	a_hold_sends_pause: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_CE && inband && I_RX_HOLD && !told_q && free
		|=> state_q == serial_flow_pkg::OUT_CTRL && O_CHR_DATA == `SFC_PAUSE_CHR)
		else $error("hold did not queue a pause character");

	a_pause_one_way: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_CE && paused_q && I_RXC.valid && I_RXC.data != `SFC_PAUSE_CHR
		&& I_RXC.data != `SFC_RESUME_CHR
		|=> O_RX.valid && O_RX.data == $past(I_RXC.data))
		else $error("reception stalled while transmitter paused");

	a_rts_request: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_CE && I_FLOW == serial_flow_pkg::FLOW_MODEM && fifo_valid |=> O_RTS)
		else $error("rts low while data waits");

	a_cts_gates: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_FLOW == serial_flow_pkg::FLOW_MODEM && O_CHR_VALID
		&& state_q == serial_flow_pkg::OUT_DATA |-> pin_q[0])
		else $error("data offered without clear-to-send");

	a_cross_ready: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_CE && I_FLOW == serial_flow_pkg::FLOW_CROSS |=> O_RTS == !$past(I_RX_HOLD))
		else $error("null-modem rts does not follow receive readiness");

	a_mode_clear: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_CE && I_CFG_CLEAR |=> O_MODE == serial_flow_pkg::PORT_RS232)
		else $error("cleared configuration did not give rs232");

	a_dtr_accept: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_CE && I_FLOW == serial_flow_pkg::FLOW_DTR && I_RX_HOLD |=> !O_DTR)
		else $error("dtr high while not accepting");

	a_pause_holds: assert property (@(posedge I_MCLK) disable iff (I_RST)
		inband && paused_q |-> !fifo_pop)
		else $error("new character left while paused");

	a_flow_consumed: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_CE && inband && (is_pause || is_resume) |=> !O_RX.valid)
		else $error("flow character reached receive data");

	a_resume_sent: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_CE && inband && !I_RX_HOLD && told_q && free
		|=> state_q == serial_flow_pkg::OUT_CTRL && O_CHR_DATA == `SFC_RESUME_CHR)
		else $error("release did not queue a resume character");

	a_ctrl_offered: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_CE && state_q == serial_flow_pkg::OUT_CTRL |-> O_CHR_VALID)
		else $error("control character not offered");

	a_cross_gates: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_FLOW == serial_flow_pkg::FLOW_CROSS && O_CHR_VALID
		&& state_q == serial_flow_pkg::OUT_DATA |-> pin_q[0])
		else $error("null-modem data offered while peer not receiving");

	a_dsr_gates: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_FLOW == serial_flow_pkg::FLOW_DTR && O_CHR_VALID
		&& state_q == serial_flow_pkg::OUT_DATA |-> pin_q[1])
		else $error("data offered while peer not accepting");

	a_data_kept: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_CE && state_q == serial_flow_pkg::OUT_DATA && !(O_CHR_VALID && I_CHR_READY)
		|=> state_q == serial_flow_pkg::OUT_DATA && $stable(O_CHR_DATA))
		else $error("withheld data character was dropped");
endmodule : serial_flow_control

`default_nettype wire

// [bench/sfc_partner.sv]
// far-side model: character shifter plus modem handshake pins
// assumes the bench sets room and willingness levels
`timescale 1ns/1ps
`default_nettype none
module sfc_partner (
	input wire logic i_clk,
	input wire logic i_room,
	input wire logic i_alive,
	output logic o_ready,
	output logic o_cts,
	output logic o_dsr
);
	// clear-to-send only while there is room; in cross wiring it is the peer's rts
	assign o_cts = i_room;
	// dsr is the peer's dtr: high only while it accepts characters
	assign o_dsr = i_alive;
	// random stalls so held characters are seen waiting
	always @(posedge i_clk) o_ready <= #1 ($urandom_range(3) != 0);
endmodule : sfc_partner
`default_nettype wire

// [bench/serial_flow_control_test.sv]
// self-checking bench for serial_flow_control
// assumes sfc_partner as the far side; clock enable dropped once in the cross test
`timescale 1ns/1ps
`default_nettype none
module serial_flow_control_test;
	logic clk = 1'b0, rst = 1'b1, tx_v = 1'b0, hold = 1'b0, clr = 1'b0, load = 1'b0;
	logic room = 1'b0, alive = 1'b0, ready, chr_v, tx_rdy, rts, dtr, cts, dsr, paused;
	logic ce = 1'b1;
	logic [7:0] tx_d = 8'h00, chr_d;
	serial_flow_pkg::port_mode_type mode = serial_flow_pkg::PORT_RS232, mode_o;
	serial_flow_pkg::flow_mode_type flow = serial_flow_pkg::FLOW_NONE;
	serial_flow_pkg::chr_type rxc = '0, rx_o;
	logic [7:0] exp_q[$];
	int err_total = 0, n_tests = 0, cyc = 0, n;

	serial_flow_control uut (.I_MCLK(clk), .I_RST(rst), .I_CE(ce), .I_CFG_CLEAR(clr),
		.I_MODE_LOAD(load), .I_MODE(mode), .I_FLOW(flow), .O_MODE(mode_o), .I_TX_VALID(tx_v),
		.I_TX_DATA(tx_d), .O_TX_READY(tx_rdy), .O_CHR_VALID(chr_v), .O_CHR_DATA(chr_d),
		.I_CHR_READY(ready), .I_RXC(rxc), .O_RX(rx_o), .I_RX_HOLD(hold), .I_CTS(cts),
		.I_DSR(dsr), .O_RTS(rts), .O_DTR(dtr), .O_TX_PAUSED(paused));
	sfc_partner far_end (.i_clk(clk), .i_room(room), .i_alive(alive), .o_ready(ready),
		.o_cts(cts), .o_dsr(dsr));

	always #2.5 clk = ~clk;

	task end_sim();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task tick(input int k = 1);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick

	task start(input serial_flow_pkg::flow_mode_type f);
		flow = f;
		rst = 1'b1;
		tick(10);
		rst = 1'b0;
		tick(2);
	endtask : start

	// caller lowers valid, so back-to-back pushes never toggle it in one step
	task push(input logic [7:0] b);
		tx_d = b;
		tx_v = 1'b1;
		exp_q.push_back(b);
		while (tx_rdy !== 1'b1)
			tick();
		tick();
	endtask : push

	task recv(input logic [7:0] b);
		rxc = {1'b1, b};
		tick();
		rxc = '0;
	endtask : recv

	task drain();
		while (exp_q.size() != 0 || chr_v === 1'b1)
			tick();
	endtask : drain

	function automatic logic [7:0] rnd();
		logic [7:0] b;
		b = 8'($urandom);
		// payload keeps clear of both control values
		return (b == 8'h11 || b == 8'h13) ? 8'h5a : b;
	endfunction : rnd

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc > 5000) begin
			err_total++;
			end_sim();
		end else if (!rst && chr_v === 1'b1 && ready === 1'b1) begin
			if (exp_q.size() == 0)
				chk("spare char", {1'b1, chr_d}, 9'h000);
			else
				chk("char out", {1'b0, chr_d}, {1'b0, exp_q.pop_front()});
		end
	end

	initial begin
		void'($urandom(32'h0000_935b));
		start(serial_flow_pkg::FLOW_NONE);
		chk("mode reset", mode_o, serial_flow_pkg::PORT_RS232);
		for (int i = 1; i < 4; i++) begin
			mode = serial_flow_pkg::port_mode_type'(i);
			load = 1'b1;
			tick();
			load = 1'b0;
			chk("mode load", mode_o, (i == 3) ? 2'h2 : 2'(i));
		end
		clr = 1'b1;
		tick();
		clr = 1'b0;
		chk("mode clear", mode_o, serial_flow_pkg::PORT_RS232);
		$display("mode test done");

		start(serial_flow_pkg::FLOW_MODEM);
		n = 0;
		while (tx_rdy === 1'b1) begin
			push(rnd());
			n++;
		end
		tx_v = 1'b0;
		chk("fifo full", 9'(n), 9'h008);
		tick(8);
		chk("gated char", chr_v, 0);
		chk("rts request", rts, 1);
		room = 1'b1;
		drain();
		tick(3);
		chk("rts idle", rts, 0);
		$display("modem test done");

		room = 1'b0;
		start(serial_flow_pkg::FLOW_CROSS);
		hold = 1'b1;
		push(rnd());
		tx_v = 1'b0;
		tick(2);
		chk("cross rts hold", rts, 0);
		tick(6);
		chk("cross gated", chr_v, 9'h000);
		ce = 1'b0;
		room = 1'b1;
		hold = 1'b0;
		tick(8);
		chk("ce frozen", {tx_rdy, chr_v, rts}, 9'h000);
		ce = 1'b1;
		tick(2);
		chk("cross rts free", rts, 1);
		drain();
		$display("cross test done");

		start(serial_flow_pkg::FLOW_DTR);
		hold = 1'b1;
		push(rnd());
		tx_v = 1'b0;
		tick(8);
		chk("dtr pins", {rts, dtr}, 2'b10);
		chk("dsr gate", chr_v, 0);
		alive = 1'b1;
		hold = 1'b0;
		drain();
		chk("dtr free", dtr, 1);
		$display("dtr test done");

		start(serial_flow_pkg::FLOW_INBAND);
		recv(8'h13);
		chk("pause eaten", rx_o.valid, 0);
		chk("paused", paused, 1);
		recv(8'h41);
		chk("rx while paused", rx_o, 9'h141);
		exp_q.push_back(8'h13);
		hold = 1'b1;
		drain();
		push(rnd());
		tx_v = 1'b0;
		tick(8);
		chk("held char", chr_v, 0);
		recv(8'h11);
		chk("resume eaten", rx_o.valid, 0);
		chk("resumed", paused, 0);
		drain();
		exp_q.push_back(8'h11);
		hold = 1'b0;
		drain();
		$display("inband test done");
		end_sim();
	end
endmodule : serial_flow_control_test
`default_nettype wire
